// file: src/lfpl_pkg.sv
// Package: register map, field layout, reset values and carrier types of the low-frequency prescaler block
package lfpl_pkg;
   // Register byte offsets
   localparam logic [11:0] OFS_SYNC_BUSY = 12'h050;
   localparam logic [11:0] OFS_A_PRESC = 12'h068;
   localparam logic [11:0] OFS_B_PRESC = 12'h070;
   localparam logic [11:0] OFS_PCNT_CTRL = 12'h078;
   localparam logic [11:0] OFS_DISP_CTRL = 12'h07C;
   localparam logic [11:0] OFS_PIN_ROUTE = 12'h080;
   localparam logic [11:0] OFS_CFG_LOCK = 12'h084;
   // A-branch prescaler fields
   localparam int POS_SENSOR = 0;
   localparam int POS_RTC = 4;
   localparam int POS_TIMER = 8;
   localparam int POS_DISP_PRE = 12;
   // B-branch prescaler field
   localparam int POS_UART = 0;
   // Pulse counter control fields
   localparam int POS_PCNT_GATE = 0;
   localparam int POS_PCNT_SEL = 1;
   // Display control fields
   localparam int POS_FRAME = 0;
   localparam int POS_BOOST_ON = 3;
   localparam int POS_BOOST_DIV = 4;
   // Routing fields
   localparam int POS_CK0_ON = 0;
   localparam int POS_CK1_ON = 1;
   localparam int POS_LOCATION = 2;
   // Status and lock fields
   localparam int POS_A_BUSY = 2;
   localparam int POS_B_BUSY = 6;
   localparam int POS_LOCKED = 0;
   // Reset values and the unlock key
   localparam logic [13:0] RST_A_PRESC = 14'h0000;
   localparam logic [1:0] RST_B_PRESC = 2'h0;
   localparam logic [2:0] RST_BOOST_DIV = 3'h2;
   localparam logic [2:0] RST_FRAME = 3'h0;
   localparam logic [2:0] RST_LOCATION = 3'h0;
   localparam logic [15:0] PROTECTION_KEY = 16'h580E;
   // Display prescaler base: field value 0 divides by 16
   localparam logic [3:0] DISP_PRE_BASE = 4'h4;
   // Divider channel indices
   localparam int CH_RTC = 0;
   localparam int CH_TIMER = 1;
   localparam int CH_SENSOR = 2;
   localparam int CH_DISP = 3;
   localparam int CH_BOOST = 4;
   localparam int CH_UART = 5;
   localparam int NUM_CH = 6;

   // APB request from the bus master
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } lfpl_apb_req_t;

   // One-cycle clock enables handed to the low-energy peripherals
   typedef struct packed {
      logic rtc;
      logic timer;
      logic sensor;
      logic uart;
      logic disp_frame;
      logic boost;
      logic pulse_cnt;
   } lfpl_ticks_t;
endpackage : lfpl_pkg

// file: src/lfpl_pow2_div.sv
// Power-of-two enable divider: passes one input tick out of every 2**sel
module lfpl_pow2_div #(
   parameter int CNT_W = 15,
   parameter int SEL_W = 4
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Input tick and division select
   input wire logic in_tick,
   input wire logic [SEL_W-1:0] sel,
   // Divided tick
   output logic out_tick
);
   typedef struct packed {
      logic [CNT_W-1:0] cnt;
      logic tick;
   } lfpl_div_state_t;

   lfpl_div_state_t s_r;
   lfpl_div_state_t s_nxt;
   logic [CNT_W:0] one_hot;
   logic [CNT_W-1:0] mask;

   // Mask of the low sel bits; sel 0 lets every tick through
   always_comb begin
      one_hot = (CNT_W+1)'(1) << sel;
      mask = CNT_W'(one_hot - (CNT_W+1)'(1));
      s_nxt = s_r;
      s_nxt.tick = in_tick && ((s_r.cnt & mask) == mask);
      if (in_tick) begin
         s_nxt.cnt = s_r.cnt + CNT_W'(1);
      end
   end

   // State register
   always_ff @(posedge clk) begin
      if (rst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign out_tick = s_r.tick;
endmodule : lfpl_pow2_div

// file: src/lfpl_top.sv
// Low-frequency prescalers, pulse counter clock, display dividers, clock pins and configuration lock
// Summary of operation
// - Real-time counter prescaler bits 7:4 divide A clock by 2**n, up to 32768.
// - Timer prescaler values 12 to 15 divide A clock by 4096 to 32768.
// - Sensor prescaler bits 1:0 divide A clock by 1, 2, 4 or 8.
// - UART prescaler bits 1:0 of B register divide B clock by 1 to 8.
// - Pulse counter select bit 1 picks A clock at 0, input pin at 1.
// - Pulse counter gate bit 0 enables the counter clock; resets to 0.
// - Boost divider bits 6:4, reset 2, divide A clock by 2**n up to 128.
// - Frame divider bits 2:0 divide prescaled display clock by one plus value.
// - Location bits 4:2 of routing register choose the pin placement.
// - Routing bits 1 and 0 enable clock output pins 1 and 0.
// - Writing key 0x580E to lock register unlocks protected registers.
// - Writing any other value, such as 0, locks protected registers.
// - Lock register bit 0 reads 1 when locked, 0 when unlocked.
// - Status bit 6 reads 1 while a new B prescaler value synchronises.
// - Status bit 2 reads 1 while a new A prescaler value synchronises.
module lfpl_top #(
   parameter int CNT_W = 15
) (
   // Clock and reset
   input wire logic SYS_CLK,
   input wire logic SRST,
   // APB slave
   input wire lfpl_pkg::lfpl_apb_req_t APB_REQ,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // Low-frequency clock pins and pulse counter pin
   input wire logic LOW_FREQ_A_BRANCH_CLOCK,
   input wire logic LOW_FREQ_B_BRANCH_CLOCK,
   input wire logic PULSE_COUNTER_INPUT_PIN,
   // Peripheral clock enables
   output lfpl_pkg::lfpl_ticks_t TICKS,
   output logic BOOST_ON,
   // Clock output pins
   output logic [2:0] PIN_LOCATION,
   output logic CLOCK_OUTPUT0,
   output logic CLOCK_OUTPUT0_OE_N,
   output logic CLOCK_OUTPUT1,
   output logic CLOCK_OUTPUT1_OE_N
);
   import lfpl_pkg::*;

   typedef struct packed {
      logic [2:0] sync_a;
      logic [2:0] sync_b;
      logic [2:0] sync_p;
      logic lvl_a;
      logic lvl_b;
      logic lvl_p;
      logic tick_a;
      logic tick_b;
      logic tick_p;
      logic [13:0] a_presc_sw;
      logic [13:0] a_presc_act;
      logic a_pend;
      logic [1:0] b_presc_sw;
      logic [1:0] b_presc_act;
      logic b_pend;
      logic pcnt_sel;
      logic pcnt_gate;
      logic pcnt_tick;
      logic [2:0] boost_div;
      logic boost_on;
      logic [2:0] frame_div;
      logic [2:0] frame_cnt;
      logic frame_tick;
      logic [2:0] location;
      logic ck0_oe_n;
      logic ck1_oe_n;
      logic locked;
      logic ready;
      logic slverr;
      logic [31:0] rdata;
   } lfpl_state_t;

   lfpl_state_t s_r;
   lfpl_state_t s_nxt;
   logic [NUM_CH-1:0] ch_in;
   logic [NUM_CH-1:0] ch_out;
   logic [3:0] ch_sel [NUM_CH];
   logic setup;
   logic wr_acc;
   logic wr_a;
   logic wr_b;
   logic wr_pcnt;

   ////////////////////////////////////////////////////////////////////////////
   // Divider channels

   // Active prescaler values steer the dividers, not the software copies
   always_comb begin
      ch_in = '0;
      ch_in[CH_RTC] = s_r.tick_a;
      ch_in[CH_TIMER] = s_r.tick_a;
      ch_in[CH_SENSOR] = s_r.tick_a;
      ch_in[CH_DISP] = s_r.tick_a;
      ch_in[CH_BOOST] = s_r.tick_a && s_r.boost_on;
      ch_in[CH_UART] = s_r.tick_b;
      ch_sel[CH_RTC] = s_r.a_presc_act[POS_RTC +: 4];
      ch_sel[CH_TIMER] = s_r.a_presc_act[POS_TIMER +: 4];
      ch_sel[CH_SENSOR] = {2'b00, s_r.a_presc_act[POS_SENSOR +: 2]};
      ch_sel[CH_DISP] = DISP_PRE_BASE + {2'b00, s_r.a_presc_act[POS_DISP_PRE +: 2]};
      ch_sel[CH_BOOST] = {1'b0, s_r.boost_div};
      ch_sel[CH_UART] = {2'b00, s_r.b_presc_act};
   end

   // One divider per channel
   genvar gi;
   generate
      for (gi = 0; gi < NUM_CH; gi++) begin : g_div
         lfpl_pow2_div #(
            .CNT_W(CNT_W),
            .SEL_W(4)
         ) u_div (
            .clk(SYS_CLK),
            .rst(SRST),
            .in_tick(ch_in[gi]),
            .sel(ch_sel[gi]),
            .out_tick(ch_out[gi])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Bus decode

   // Data is prepared in the setup cycle so the access phase ends at once
   assign setup = APB_REQ.psel && !APB_REQ.penable;
   assign wr_acc = APB_REQ.psel && APB_REQ.penable && s_r.ready && APB_REQ.pwrite && !s_r.slverr;
   // Protected registers drop writes while locked; lock register never does
   assign wr_a = wr_acc && (APB_REQ.paddr == OFS_A_PRESC) && !s_r.locked;
   assign wr_b = wr_acc && (APB_REQ.paddr == OFS_B_PRESC) && !s_r.locked;
   assign wr_pcnt = wr_acc && (APB_REQ.paddr == OFS_PCNT_CTRL) && !s_r.locked;

   ////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      s_nxt = s_r;
      // Three-stage pin synchronisers; a level counts once stages two and three agree
      s_nxt.sync_a = {s_r.sync_a[1:0], LOW_FREQ_A_BRANCH_CLOCK};
      s_nxt.sync_b = {s_r.sync_b[1:0], LOW_FREQ_B_BRANCH_CLOCK};
      s_nxt.sync_p = {s_r.sync_p[1:0], PULSE_COUNTER_INPUT_PIN};
      if (s_r.sync_a[2] == s_r.sync_a[1]) begin
         s_nxt.lvl_a = s_r.sync_a[2];
      end
      if (s_r.sync_b[2] == s_r.sync_b[1]) begin
         s_nxt.lvl_b = s_r.sync_b[2];
      end
      if (s_r.sync_p[2] == s_r.sync_p[1]) begin
         s_nxt.lvl_p = s_r.sync_p[2];
      end
      s_nxt.tick_a = s_r.sync_a[2] && s_r.sync_a[1] && !s_r.lvl_a;
      s_nxt.tick_b = s_r.sync_b[2] && s_r.sync_b[1] && !s_r.lvl_b;
      s_nxt.tick_p = s_r.sync_p[2] && s_r.sync_p[1] && !s_r.lvl_p;

      // Pulse counter clock: source select, then gate
      s_nxt.pcnt_tick = s_r.pcnt_gate && (s_r.pcnt_sel ? s_r.tick_p : s_r.tick_a);

      // Frame divider counts prescaled display ticks up to the field value
      s_nxt.frame_tick = 1'b0;
      if (ch_out[CH_DISP]) begin
         if (s_r.frame_cnt >= s_r.frame_div) begin
            s_nxt.frame_tick = 1'b1;
            s_nxt.frame_cnt = 3'h0;
         end else begin
            s_nxt.frame_cnt = s_r.frame_cnt + 3'h1;
         end
      end

      // New prescaler values cross at the next branch edge; a write wins over the edge
      if (s_r.tick_a && s_r.a_pend) begin
         s_nxt.a_presc_act = s_r.a_presc_sw;
         s_nxt.a_pend = 1'b0;
      end
      if (s_r.tick_b && s_r.b_pend) begin
         s_nxt.b_presc_act = s_r.b_presc_sw;
         s_nxt.b_pend = 1'b0;
      end
      if (wr_a) begin
         s_nxt.a_presc_sw = {APB_REQ.pwdata[POS_DISP_PRE +: 2], APB_REQ.pwdata[POS_TIMER +: 4],
                             APB_REQ.pwdata[POS_RTC +: 4], 2'b00, APB_REQ.pwdata[POS_SENSOR +: 2]};
         s_nxt.a_pend = 1'b1;
      end
      if (wr_b) begin
         s_nxt.b_presc_sw = APB_REQ.pwdata[POS_UART +: 2];
         s_nxt.b_pend = 1'b1;
      end
      if (wr_pcnt) begin
         s_nxt.pcnt_sel = APB_REQ.pwdata[POS_PCNT_SEL];
         s_nxt.pcnt_gate = APB_REQ.pwdata[POS_PCNT_GATE];
      end
      if (wr_acc && APB_REQ.paddr == OFS_DISP_CTRL) begin
         s_nxt.boost_div = APB_REQ.pwdata[POS_BOOST_DIV +: 3];
         s_nxt.boost_on = APB_REQ.pwdata[POS_BOOST_ON];
         s_nxt.frame_div = APB_REQ.pwdata[POS_FRAME +: 3];
      end
      if (wr_acc && APB_REQ.paddr == OFS_PIN_ROUTE) begin
         s_nxt.location = APB_REQ.pwdata[POS_LOCATION +: 3];
         s_nxt.ck1_oe_n = !APB_REQ.pwdata[POS_CK1_ON];
         s_nxt.ck0_oe_n = !APB_REQ.pwdata[POS_CK0_ON];
      end
      if (wr_acc && APB_REQ.paddr == OFS_CFG_LOCK) begin
         s_nxt.locked = (APB_REQ.pwdata[15:0] != PROTECTION_KEY);
      end

      // Answer: ready in the first access cycle, error on an unmapped address
      s_nxt.ready = setup;
      s_nxt.slverr = 1'b0;
      if (setup) begin
         s_nxt.rdata = 32'h0000_0000;
         case (APB_REQ.paddr)
            OFS_SYNC_BUSY: begin
               s_nxt.rdata[POS_A_BUSY] = s_r.a_pend;
               s_nxt.rdata[POS_B_BUSY] = s_r.b_pend;
            end
            OFS_A_PRESC: begin
               s_nxt.rdata[13:0] = s_r.a_presc_sw;
            end
            OFS_B_PRESC: begin
               s_nxt.rdata[POS_UART +: 2] = s_r.b_presc_sw;
            end
            OFS_PCNT_CTRL: begin
               s_nxt.rdata[POS_PCNT_SEL] = s_r.pcnt_sel;
               s_nxt.rdata[POS_PCNT_GATE] = s_r.pcnt_gate;
            end
            OFS_DISP_CTRL: begin
               s_nxt.rdata[POS_BOOST_DIV +: 3] = s_r.boost_div;
               s_nxt.rdata[POS_BOOST_ON] = s_r.boost_on;
               s_nxt.rdata[POS_FRAME +: 3] = s_r.frame_div;
            end
            OFS_PIN_ROUTE: begin
               s_nxt.rdata[POS_LOCATION +: 3] = s_r.location;
               s_nxt.rdata[POS_CK1_ON] = !s_r.ck1_oe_n;
               s_nxt.rdata[POS_CK0_ON] = !s_r.ck0_oe_n;
            end
            OFS_CFG_LOCK: begin
               s_nxt.rdata[POS_LOCKED] = s_r.locked;
            end
            default: begin
               s_nxt.slverr = 1'b1;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register

   // Unlocked after reset, as the lock field resets to zero
   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         s_r <= '0;
         s_r.a_presc_sw <= RST_A_PRESC;
         s_r.a_presc_act <= RST_A_PRESC;
         s_r.b_presc_sw <= RST_B_PRESC;
         s_r.b_presc_act <= RST_B_PRESC;
         s_r.boost_div <= RST_BOOST_DIV;
         s_r.frame_div <= RST_FRAME;
         s_r.location <= RST_LOCATION;
         // Pin enables reset off, so the active-low enables reset high
         s_r.ck0_oe_n <= 1'b1;
         s_r.ck1_oe_n <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign PRDATA = s_r.rdata;
   assign PREADY = s_r.ready;
   assign PSLVERR = s_r.slverr;
   assign TICKS.rtc = ch_out[CH_RTC];
   assign TICKS.timer = ch_out[CH_TIMER];
   assign TICKS.sensor = ch_out[CH_SENSOR];
   assign TICKS.uart = ch_out[CH_UART];
   assign TICKS.disp_frame = s_r.frame_tick;
   assign TICKS.boost = ch_out[CH_BOOST];
   assign TICKS.pulse_cnt = s_r.pcnt_tick;
   assign BOOST_ON = s_r.boost_on;
   assign PIN_LOCATION = s_r.location;
   // Pins carry the clean branch levels; drivers only on when enabled
   assign CLOCK_OUTPUT0 = s_r.lvl_a;
   assign CLOCK_OUTPUT1 = s_r.lvl_b;
   assign CLOCK_OUTPUT0_OE_N = s_r.ck0_oe_n;
   assign CLOCK_OUTPUT1_OE_N = s_r.ck1_oe_n;

   ////////////////////////////////////////////////////////////////////////////
   // Assertions

   AST_LOCK_READ:
   assert property (@(posedge SYS_CLK) disable iff (SRST)
      (setup && APB_REQ.paddr == OFS_CFG_LOCK) |=> (PRDATA[POS_LOCKED] == $past(s_r.locked)))
      else $error("lock status read back wrong");

   AST_KEY_UNLOCK:
   assert property (@(posedge SYS_CLK) disable iff (SRST)
      (wr_acc && APB_REQ.paddr == OFS_CFG_LOCK && APB_REQ.pwdata[15:0] == PROTECTION_KEY) |=> !s_r.locked)
      else $error("key write did not unlock");

   AST_ZERO_LOCKS:
   assert property (@(posedge SYS_CLK) disable iff (SRST)
      (wr_acc && APB_REQ.paddr == OFS_CFG_LOCK && APB_REQ.pwdata[15:0] == 16'h0000) |=> s_r.locked)
      else $error("zero write did not lock");

   AST_LOCKED_IGNORED:
   assert property (@(posedge SYS_CLK) disable iff (SRST)
      (s_r.locked && wr_acc && APB_REQ.paddr == OFS_PCNT_CTRL) |=> $stable({s_r.pcnt_sel, s_r.pcnt_gate}))
      else $error("locked register changed");

   AST_GATE_OFF:
   assert property (@(posedge SYS_CLK) disable iff (SRST)
      !s_r.pcnt_gate |=> !TICKS.pulse_cnt)
      else $error("pulse counter clock while gated");

   AST_CLKOUT_OE:
   assert property (@(posedge SYS_CLK) disable iff (SRST)
      (wr_acc && APB_REQ.paddr == OFS_PIN_ROUTE) |=>
      (CLOCK_OUTPUT0_OE_N == !$past(APB_REQ.pwdata[POS_CK0_ON])) &&
      (CLOCK_OUTPUT1_OE_N == !$past(APB_REQ.pwdata[POS_CK1_ON])))
      else $error("clock pin enable not applied");

   AST_B_BUSY:
   assert property (@(posedge SYS_CLK) disable iff (SRST)
      (wr_b ##1 !s_r.tick_b ##1 (setup && APB_REQ.paddr == OFS_SYNC_BUSY)) |=> PRDATA[POS_B_BUSY])
      else $error("B busy flag not raised after write");

   AST_A_BUSY_CLEAR:
   assert property (@(posedge SYS_CLK) disable iff (SRST)
      (s_r.a_pend && s_r.tick_a && !wr_a) |=> !s_r.a_pend && (s_r.a_presc_act == $past(s_r.a_presc_sw)))
      else $error("A prescaler not applied at branch edge");

   AST_RTC_UNDIVIDED:
   assert property (@(posedge SYS_CLK) disable iff (SRST)
      (s_r.tick_a && s_r.a_presc_act[POS_RTC +: 4] == 4'h0) |=> TICKS.rtc)
      else $error("undivided RTC tick missing");

   AST_FRAME_DIV1:
   assert property (@(posedge SYS_CLK) disable iff (SRST)
      (ch_out[CH_DISP] && s_r.frame_div == 3'h0) |=> TICKS.disp_frame)
      else $error("frame tick missing at divide by one");

   AST_BOOST_OFF:
   assert property (@(posedge SYS_CLK) disable iff (SRST)
      !s_r.boost_on [*2] |=> !TICKS.boost)
      else $error("boost tick while boost is off");
endmodule : lfpl_top

// file: verif/lfpl_lf_model.sv
// Model of the low-frequency branch sources and of the peripherals that take the clock enables
module lfpl_lf_model (
   // System clock
   input wire logic sys_clk,
   // Enables from the block
   input wire lfpl_pkg::lfpl_ticks_t ticks,
   // Branch clocks and pulse counter pin
   output logic a_clk,
   output logic b_clk,
   output logic pin,
   // Event counts: 0..6 enables in struct order, 7 A edges, 8 B edges, 9 pin edges
   output int cnt [10]
);
   timeunit 1ns;
   timeprecision 1ns;
   import lfpl_pkg::*;
   ////////////////////////////////////////////////////////////////////////////////
   // Oscillator branches run free; periods of 12, 14 and 10 system cycles keep every level over 3 cycles
   initial begin
      a_clk = 1'b0;
      forever #300 a_clk = ~a_clk;
   end
   initial begin
      b_clk = 1'b0;
      #37;
      forever #350 b_clk = ~b_clk;
   end
   initial begin
      pin = 1'b0;
      #91;
      forever #250 pin = ~pin;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Counters start cleared
   initial begin
      cnt = '{default: 0};
   end
   // Each enable is one cycle wide, so a sample per edge counts it once
   always @(posedge sys_clk) begin
      for (int i = 0; i < 7; i++) begin
         cnt[i] <= cnt[i] + int'(ticks[6-i]);
      end
   end
   // Source edges, counted so that the bench can open windows aligned to them
   always @(posedge a_clk) cnt[7] <= cnt[7] + 1;
   always @(posedge b_clk) cnt[8] <= cnt[8] + 1;
   always @(posedge pin) cnt[9] <= cnt[9] + 1;
endmodule : lfpl_lf_model

// file: verif/tb_top.sv
// Self-checking bench of the low-frequency prescaler block
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import lfpl_pkg::*;
   logic sys_clk = 1'b0;
   logic srst = 1'b1;
   lfpl_apb_req_t req = '0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   lfpl_ticks_t ticks;
   logic boost_on;
   logic [2:0] pin_location;
   logic ck0_oe_n;
   logic ck1_oe_n;
   logic ck0;
   logic ck1;
   logic a_clk;
   logic b_clk;
   logic pin;
   int cnt [10];
   int d [10];
   int err_count = 0;
   int checks = 0;
   int cycles = 0;
   logic [31:0] rd;
   logic er;
   ////////////////////////////////////////////////////////////////////////////////
   // Block and its far side
   lfpl_top #(.CNT_W(15)) DUT (.SYS_CLK(sys_clk), .SRST(srst), .APB_REQ(req), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr), .LOW_FREQ_A_BRANCH_CLOCK(a_clk),
      .LOW_FREQ_B_BRANCH_CLOCK(b_clk), .PULSE_COUNTER_INPUT_PIN(pin), .TICKS(ticks),
      .BOOST_ON(boost_on), .PIN_LOCATION(pin_location), .CLOCK_OUTPUT0(ck0), .CLOCK_OUTPUT0_OE_N(ck0_oe_n),
      .CLOCK_OUTPUT1(ck1), .CLOCK_OUTPUT1_OE_N(ck1_oe_n));
   lfpl_lf_model u_lf (.sys_clk(sys_clk), .ticks(ticks), .a_clk(a_clk), .b_clk(b_clk), .pin(pin), .cnt(cnt));
   ////////////////////////////////////////////////////////////////////////////////
   // 50 ns system clock
   initial begin
      forever #25 sys_clk = ~sys_clk;
   end
   // Run is about 50k cycles; the ceiling leaves room but cuts a hang short
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 90000) begin
         err_count++;
         summarize();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic summarize();
      if (err_count == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : summarize
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         $display("BAD %s expected %h seen %h", what, exp, got);
         err_count++;
      end
   endtask : chk
   // One APB transfer; pready and the answer are taken at the rising edge that ends the access
   task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge sys_clk);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wd};
      @(posedge sys_clk);
      req.penable <= 1'b1;
      @(posedge sys_clk);
      while (pready !== 1'b1 && n < 20) begin
         @(posedge sys_clk);
         n++;
      end
      rd = prdata;
      er = pslverr;
      if (n == 20) chk("pready", 1, 0);
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask : apb
   // Read check: pwdata carries zeros, the data is compared and pslverr must stay clear
   task automatic rchk(input string what, input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, '0);
      chk(what, exp, rd);
      chk("pslverr", 0, er);
   endtask : rchk
   // Poll until both synchronisers are free
   task automatic idle();
      int n;
      n = 0;
      apb(1'b0, OFS_SYNC_BUSY, '0);
      while ((rd[POS_A_BUSY] | rd[POS_B_BUSY]) !== 1'b0 && n < 60) begin
         apb(1'b0, OFS_SYNC_BUSY, '0);
         n++;
      end
      chk("sync_idle", 0, rd & 32'h0000_0044);
   endtask : idle
   // Wait until just after a source edge, then a few cycles, so a write lands well before the next tick
   task automatic after_edge(input int idx);
      int t0;
      t0 = cnt[idx];
      while (cnt[idx] == t0) @(posedge sys_clk);
      repeat (5) @(posedge sys_clk);
   endtask : after_edge
   // Count events over n edges of source idx; a whole number of periods gives exact counts
   task automatic window(input int idx, input int n);
      int s [10];
      after_edge(idx);
      s = cnt;
      while (cnt[idx] - s[idx] < n) @(posedge sys_clk);
      for (int i = 0; i < 10; i++) d[i] = cnt[i] - s[i];
   endtask : window
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      rchk("a_presc", OFS_A_PRESC, 32'h0000_0000);
      rchk("b_presc", OFS_B_PRESC, 32'h0000_0000);
      rchk("pcnt", OFS_PCNT_CTRL, 32'h0000_0000);
      rchk("disp", OFS_DISP_CTRL, 32'h0000_0020);
      rchk("route", OFS_PIN_ROUTE, 32'h0000_0000);
      rchk("lock", OFS_CFG_LOCK, 32'h0000_0000);
      chk("oe_n", 2'b11, {ck1_oe_n, ck0_oe_n});
      apb(1'b0, 12'h0FC, '0);
      chk("unmapped_err", 1, er);
      chk("unmapped_data", 0, rd);
   endtask : t_reset
   task automatic t_divide();
      apb(1'b1, OFS_DISP_CTRL, 32'h0000_007F);
      apb(1'b1, OFS_PCNT_CTRL, 32'h0000_0001);
      after_edge(7);
      apb(1'b1, OFS_A_PRESC, 32'h0000_0C53);
      rchk("a_busy", OFS_SYNC_BUSY, 32'h0000_0004);
      rchk("a_presc", OFS_A_PRESC, 32'h0000_0C53);
      idle();
      window(7, 4096);
      chk("rtc", 4096 >> 5, d[0]);
      chk("timer", 1, d[1]);
      chk("sensor", 4096 >> 3, d[2]);
      chk("frame", 4096 / (16 * 8), d[4]);
      chk("boost", 4096 >> 7, d[5]);
      chk("pulse_a", 4096, d[6]);
      chk("boost_on", 1, boost_on);
   endtask : t_divide
   task automatic t_uart();
      after_edge(8);
      apb(1'b1, OFS_B_PRESC, 32'h0000_0003);
      rchk("b_busy", OFS_SYNC_BUSY, 32'h0000_0040);
      rchk("b_presc", OFS_B_PRESC, 32'h0000_0003);
      idle();
      window(8, 64);
      chk("uart", 64 >> 3, d[3]);
   endtask : t_uart
   task automatic t_pin();
      apb(1'b1, OFS_PCNT_CTRL, 32'h0000_0003);
      window(9, 32);
      chk("pulse_pin", 32, d[6]);
      apb(1'b1, OFS_PCNT_CTRL, 32'h0000_0000);
      apb(1'b1, OFS_DISP_CTRL, 32'h0000_0077);
      window(7, 16);
      chk("pulse_off", 0, d[6]);
      chk("boost_off", 0, d[5]);
      chk("boost_on", 0, boost_on);
   endtask : t_pin
   task automatic t_route();
      for (int loc = 0; loc < 3; loc++) begin
         apb(1'b1, OFS_PIN_ROUTE, {27'h0, 3'(loc), 2'b10});
         rchk("route", OFS_PIN_ROUTE, {27'h0, 3'(loc), 2'b10});
         chk("location", 3'(loc), pin_location);
         chk("oe_n_1", 2'b01, {ck1_oe_n, ck0_oe_n});
      end
      apb(1'b1, OFS_PIN_ROUTE, 32'h0000_0001);
      rchk("route", OFS_PIN_ROUTE, 32'h0000_0001);
      chk("oe_n_0", 2'b10, {ck1_oe_n, ck0_oe_n});
      // Pins follow the filtered branch levels a few cycles behind the source
      after_edge(7);
      chk("ck0_high", 1, ck0);
      repeat (6) @(posedge sys_clk);
      chk("ck0_low", 0, ck0);
      after_edge(8);
      chk("ck1_high", 1, ck1);
   endtask : t_route
   task automatic t_lock();
      apb(1'b1, OFS_CFG_LOCK, 32'h0000_0000);
      rchk("locked", OFS_CFG_LOCK, 32'h0000_0001);
      apb(1'b1, OFS_PCNT_CTRL, 32'h0000_0001);
      rchk("pcnt_kept", OFS_PCNT_CTRL, 32'h0000_0000);
      apb(1'b1, OFS_A_PRESC, 32'h0000_0000);
      rchk("a_kept", OFS_A_PRESC, 32'h0000_0C53);
      apb(1'b1, OFS_B_PRESC, 32'h0000_0000);
      rchk("b_kept", OFS_B_PRESC, 32'h0000_0003);
      apb(1'b1, OFS_CFG_LOCK, {16'h0000, PROTECTION_KEY});
      rchk("unlocked", OFS_CFG_LOCK, 32'h0000_0000);
      apb(1'b1, OFS_PCNT_CTRL, 32'h0000_0001);
      rchk("pcnt_new", OFS_PCNT_CTRL, 32'h0000_0001);
      apb(1'b1, OFS_CFG_LOCK, 32'h0000_580F);
      rchk("relocked", OFS_CFG_LOCK, 32'h0000_0001);
   endtask : t_lock
   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (12) @(posedge sys_clk);
      srst <= 1'b0;
      t_reset();
      t_divide();
      t_uart();
      t_pin();
      t_route();
      t_lock();
      summarize();
   end
endmodule : tb_top
